// [shared/alarm_cfg.svh]
// Constants of the alarm annunciator: sizes, encodings, reset values.
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define ALARM_COUNT     128
`define ALARM_IDX_W     7
`define GROUP_SIZE      32
`define STAMP_W         32

// ------------------------------------------------------------
// Event buffer selection encodings
// ------------------------------------------------------------
`define EVT_SEL_BOTH    2'h0
`define EVT_SEL_ON      2'h1
`define EVT_SEL_OFF     2'h2
`define EVT_SEL_BOTH_B  2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_BUZZER      1'h0
`define RST_BACK_ARMED  1'h0
`define RST_STAMP       32'h0000_0000

`endif

// [shared/alarm_pkg.sv]
// Types shared by the alarm annunciator modules.
package alarm_pkg;

	typedef enum logic [1:0] {
		event_group_first,
		event_group_second,
		event_group_third,
		event_group_fourth
	} event_group_t;

	typedef enum {
		ALM_INACTIVE,
		ALM_ACTIVE,
		ALM_ACTIVE_ACK,
		ALM_INACTIVE_UNACK
	} alarm_state_t;

endpackage

// [shared/alarm_evt_if.sv]
// Carrier of per-alarm status changes from annunciator to event generator.
`timescale 1ns/1ps
interface alarm_evt_if #(
	parameter int NUM_ALARMS = 128
);
	logic [NUM_ALARMS-1:0] rise;
	logic [NUM_ALARMS-1:0] fall;

	modport src  (output rise, output fall);
	modport sink (input rise, input fall);
endinterface

// [hdl/alarm_event_gen.sv]
// Event generator: pending ON/OFF changes, ordered emission to event buffer.
`timescale 1ns/1ps
`include "alarm_cfg.svh"
module alarm_event_gen
	import alarm_pkg::*;
#(
	parameter int NUM_ALARMS = `ALARM_COUNT
) (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	// Status changes
	alarm_evt_if.sink                    chg,
	// Settings
	input  wire logic [1:0]              eventSel,
	input  wire logic [NUM_ALARMS-1:0]   historyMask,
	// Event buffer side
	output logic                         evtValid,
	input  wire logic                    evtReady,
	output logic [`ALARM_IDX_W-1:0]      evtIndex_ff,
	output logic                         evtOn_ff,
	output event_group_t                 evtGroup_ff,
	output logic                         evtToBuffer_ff,
	output logic                         evtToHistory_ff,
	output logic [`STAMP_W-1:0]          evtStamp_ff
);

	localparam int PEND_W = 2 * NUM_ALARMS;

	logic [PEND_W-1:0]        pend_ff;
	logic [PEND_W-1:0]        newPend;
	logic [PEND_W-1:0]        takenMask;
	logic                     outValid_ff;
	logic                     load;
	logic                     anyPend;
	logic [`ALARM_IDX_W:0]    pickSlot;
	logic [`STAMP_W-1:0]      stamp_ff;
	logic                     keepOn;
	logic                     keepOff;

	// ------------------------------------------------------------
	// Selection of kinds kept
	// ------------------------------------------------------------
	assign keepOn  = (eventSel != `EVT_SEL_OFF);               // [R8]
	assign keepOff = (eventSel != `EVT_SEL_ON);                // [R8]

	// Even slot = ON, odd slot = OFF; all alarms latched the same cycle
	genvar g;
	generate
		for (g = 0; g < NUM_ALARMS; g++) begin : gSlot
			assign newPend[2*g]   = chg.rise[g]
				& (keepOn | historyMask[g]);               // [R7] [R9] [R13]
			assign newPend[2*g+1] = chg.fall[g] & keepOff;     // [R7] [R13]
		end
	endgenerate

	// ------------------------------------------------------------
	// Lowest slot first: alarm order, ON before OFF
	// ------------------------------------------------------------
	always_comb begin
		anyPend  = 1'b0;
		pickSlot = '0;
		for (int i = PEND_W - 1; i >= 0; i--) begin
			if (pend_ff[i]) begin
				anyPend  = 1'b1;
				pickSlot = (`ALARM_IDX_W+1)'(i);               // [R13]
			end
		end
	end

	assign load     = anyPend && (!outValid_ff || evtReady);
	assign evtValid = outValid_ff;

	always_comb begin
		takenMask = '0;
		if (load) begin
			takenMask[pickSlot] = 1'b1;
		end
	end

	// New change wins over the emission of the same slot
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= (pend_ff & ~takenMask) | newPend;       // [R13]
		end
	end

	// ------------------------------------------------------------
	// Time base for stamps
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stamp_ff <= `RST_STAMP;
		end else begin
			stamp_ff <= stamp_ff + `STAMP_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Output word
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			outValid_ff     <= 1'b0;
			evtIndex_ff     <= '0;
			evtOn_ff        <= 1'b0;
			evtGroup_ff     <= event_group_first;
			evtToBuffer_ff  <= 1'b0;
			evtToHistory_ff <= 1'b0;
			evtStamp_ff     <= '0;
		end else if (load) begin
			outValid_ff     <= 1'b1;
			evtIndex_ff     <= pickSlot[`ALARM_IDX_W:1];
			evtOn_ff        <= !pickSlot[0];
			evtGroup_ff     <= event_group_t'(pickSlot[`ALARM_IDX_W:6]); // [R12]
			evtToBuffer_ff  <= pickSlot[0] ? keepOff : keepOn;          // [R8]
			evtToHistory_ff <= !pickSlot[0]
				&& historyMask[pickSlot[`ALARM_IDX_W:1]];               // [R9]
			evtStamp_ff     <= stamp_ff;                                // [R9]
		end else if (evtReady) begin
			outValid_ff     <= 1'b0;
		end
	end

endmodule

// [hdl/alarm_annunciator.sv]
// Alarm annunciator: per-alarm states, clearing, buzzer and status changes.
`timescale 1ns/1ps
`include "alarm_cfg.svh"
// Overview of operation
// R1: Global clear input acknowledges all alarms too.
// R2: Clear button should be momentary press-release.
// R3: Buzzer output asserts on any alarm activation.
// R4: Buzzer reaches world only through relay output.
// R5: Back button or mute input silences buzzer.
// R6: Latched source clears only after back press.
// R7: ON and OFF events per alarm change.
// R8: Setting picks ON, OFF or both kept.
// R9: Masked activations stamped into history record.
// R10: Fallen alarm stays unacknowledged until reset command.
// R11: Active alarm clearable only when enabled.
// R12: Four event groups of thirty-two alarms.
// R13: All alarms evaluated together, ordered events.
module alarm_annunciator
	import alarm_pkg::*;
#(
	parameter int NUM_ALARMS = `ALARM_COUNT
) (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	// Monitored signals
	input  wire logic [NUM_ALARMS-1:0]   alarmIn,
	input  wire logic [NUM_ALARMS-1:0]   latchedSrc,
	// Panel and logic controls
	input  wire logic                    clearBtn,
	input  wire logic                    globalClear,
	input  wire logic                    backBtn,
	input  wire logic                    buzzerMute,
	// Settings
	input  wire logic                    clearActiveEn,
	input  wire logic [1:0]              eventSel,
	input  wire logic [NUM_ALARMS-1:0]   historyMask,
	// Output relay and latch release
	output logic                         buzzerRelay_ff,
	output logic [NUM_ALARMS-1:0]        latchRelease_ff,
	// Alarm status
	output logic [NUM_ALARMS-1:0]        alarmActive_ff,
	output logic [NUM_ALARMS-1:0]        alarmAcked_ff,
	output logic [NUM_ALARMS-1:0]        alarmUnack_ff,
	output logic                         anyUnack_ff,
	// Event buffer
	output logic                         evtValid,
	input  wire logic                    evtReady,
	output logic [`ALARM_IDX_W-1:0]      evtIndex_ff,
	output logic                         evtOn_ff,
	output event_group_t                 evtGroup_ff,
	output logic                         evtToBuffer_ff,
	output logic                         evtToHistory_ff,
	output logic [`STAMP_W-1:0]          evtStamp_ff
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Group code and index width cover at most four groups of 32
	generate
		if (NUM_ALARMS < 1 || NUM_ALARMS > `ALARM_COUNT) begin : gChk
			$error("NUM_ALARMS must lie between 1 and 128");
		end
	endgenerate

	logic                    clearBtnPrev_ff;
	logic                    backBtnPrev_ff;
	logic                    clearPress;
	logic                    backPress;
	logic                    clearCmd;
	logic                    backArmed_ff;
	logic [NUM_ALARMS-1:0]   prevIn_ff;
	logic [NUM_ALARMS-1:0]   activation;
	logic [NUM_ALARMS-1:0]   clearTaken;
	logic                    anyActivation;
	logic                    anyLatchedClear;

	alarm_evt_if #(.NUM_ALARMS(NUM_ALARMS)) chg ();

	// ------------------------------------------------------------
	// Button edges
	// ------------------------------------------------------------
	// Edge taken so a held button clears once; relies on momentary use
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			clearBtnPrev_ff <= 1'b0;
			backBtnPrev_ff  <= 1'b0;
		end else begin
			clearBtnPrev_ff <= clearBtn;
			backBtnPrev_ff  <= backBtn;
		end
	end

	assign clearPress = clearBtn && !clearBtnPrev_ff;               // [R2]
	assign backPress  = backBtn && !backBtnPrev_ff;
	assign clearCmd   = clearPress || globalClear;                  // [R1]

	// ------------------------------------------------------------
	// Back button arming for latched sources
	// ------------------------------------------------------------
	// A fresh back press wins over the consuming clear
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			backArmed_ff <= `RST_BACK_ARMED;
		end else if (backPress) begin
			backArmed_ff <= 1'b1;                                   // [R6]
		end else if (anyLatchedClear) begin
			backArmed_ff <= 1'b0;                                   // [R6]
		end
	end

	// ------------------------------------------------------------
	// Status change detection, all alarms in one cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			prevIn_ff <= '0;
		end else begin
			prevIn_ff <= alarmIn;                                   // [R13]
		end
	end

	assign chg.rise = alarmIn & ~prevIn_ff;                         // [R7]
	assign chg.fall = ~alarmIn & prevIn_ff;                         // [R7]

	// ------------------------------------------------------------
	// Per-alarm state machines
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_ALARMS; g++) begin : gAlm
			alarm_state_t state_ff;
			alarm_state_t nxt_state;
			logic         clrOk;

			// Latched source only clears once back has been pressed
			assign clrOk = clearCmd
				&& (!latchedSrc[g] || backArmed_ff);                // [R6]

			always_comb begin
				nxt_state        = state_ff;
				activation[g]    = 1'b0;
				clearTaken[g]    = 1'b0;
				case (state_ff)
					ALM_INACTIVE: begin
						if (alarmIn[g]) begin
							nxt_state     = ALM_ACTIVE;
							activation[g] = 1'b1;                   // [R3]
						end
					end
					ALM_ACTIVE: begin
						if (!alarmIn[g]) begin
							nxt_state = ALM_INACTIVE_UNACK;         // [R10]
						end else if (clrOk && clearActiveEn) begin
							nxt_state     = ALM_ACTIVE_ACK;         // [R11] [R1]
							clearTaken[g] = 1'b1;
						end
					end
					ALM_ACTIVE_ACK: begin
						if (!alarmIn[g]) begin
							nxt_state = ALM_INACTIVE;               // [R11]
						end
					end
					ALM_INACTIVE_UNACK: begin
						if (alarmIn[g]) begin
							nxt_state     = ALM_ACTIVE;
							activation[g] = 1'b1;                   // [R3]
						end else if (clrOk) begin
							nxt_state     = ALM_INACTIVE;           // [R10] [R1]
							clearTaken[g] = 1'b1;
						end
					end
					default: begin
						nxt_state = ALM_INACTIVE;
					end
				endcase
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					state_ff <= ALM_INACTIVE;
				end else begin
					state_ff <= nxt_state;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					alarmActive_ff[g]  <= 1'b0;
					alarmAcked_ff[g]   <= 1'b0;
					alarmUnack_ff[g]   <= 1'b0;
					latchRelease_ff[g] <= 1'b0;
				end else begin
					alarmActive_ff[g]  <= (nxt_state == ALM_ACTIVE)
						|| (nxt_state == ALM_ACTIVE_ACK);
					alarmAcked_ff[g]   <= (nxt_state == ALM_ACTIVE_ACK);
					alarmUnack_ff[g]   <= (nxt_state == ALM_ACTIVE)
						|| (nxt_state == ALM_INACTIVE_UNACK);
					latchRelease_ff[g] <= clearTaken[g]
						&& latchedSrc[g];                           // [R6]
				end
			end
		end
	endgenerate

	assign anyActivation   = |activation;
	assign anyLatchedClear = |(clearTaken & latchedSrc);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			anyUnack_ff <= 1'b0;
		end else begin
			anyUnack_ff <= |alarmUnack_ff;
		end
	end

	// ------------------------------------------------------------
	// Buzzer relay drive
	// ------------------------------------------------------------
	// No internal sounder: this flop is the only buzzer path.
	// New activation wins over a silence in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			buzzerRelay_ff <= `RST_BUZZER;
		end else if (anyActivation) begin
			buzzerRelay_ff <= 1'b1;                                 // [R3] [R4]
		end else if (backPress || buzzerMute) begin
			buzzerRelay_ff <= 1'b0;                                 // [R5]
		end
	end

	// ------------------------------------------------------------
	// Event generation
	// ------------------------------------------------------------
	alarm_event_gen #(
		.NUM_ALARMS (NUM_ALARMS)
	) uEvt (
		.clk_sys         (clk_sys),
		.rst_b           (rst_b),
		.chg             (chg),
		.eventSel        (eventSel),
		.historyMask     (historyMask),
		.evtValid        (evtValid),
		.evtReady        (evtReady),
		.evtIndex_ff     (evtIndex_ff),
		.evtOn_ff        (evtOn_ff),
		.evtGroup_ff     (evtGroup_ff),
		.evtToBuffer_ff  (evtToBuffer_ff),
		.evtToHistory_ff (evtToHistory_ff),
		.evtStamp_ff     (evtStamp_ff)
	);

endmodule

// [test/evt_sink.sv]
// Event buffer model: stalls on request and logs accepted words.
`timescale 1ns/1ps
`include "alarm_cfg.svh"
module evt_sink (
	// Clock
	input  wire logic                    clk_sys,
	// Event word
	input  wire logic                    evtValid,
	input  wire logic [`ALARM_IDX_W-1:0] evtIndex_ff,
	input  wire logic                    evtOn_ff,
	input  wire logic                    evtToBuffer_ff,
	input  wire logic                    evtToHistory_ff,
	// Control and log
	input  wire logic                    stall,
	input  wire logic                    clrLog,
	output logic                         evtReady,
	output logic [9:0]                   logWord [8],
	output int                           logCnt
);
	// Word is taken only at an edge with ready high
	assign evtReady = !stall;
	always_ff @(posedge clk_sys) begin
		if (clrLog)
			logCnt <= 0;
		else if (evtValid && evtReady && logCnt < 8) begin
			logWord[logCnt[2:0]] <= {evtToHistory_ff, evtToBuffer_ff,
				evtOn_ff, evtIndex_ff};
			logCnt <= logCnt + 1;
		end
	end
endmodule

// [test/alarm_annunciator_sva.sv]
// Checker of the annunciator's port behaviour.
`timescale 1ns/1ps
`include "alarm_cfg.svh"
module alarm_annunciator_sva
	import alarm_pkg::*;
#(
	parameter int NUM_ALARMS = 128
) (
	input wire logic                    clk_sys,
	input wire logic                    rst_b,
	input wire logic [NUM_ALARMS-1:0]   alarmIn,
	input wire logic [NUM_ALARMS-1:0]   latchedSrc,
	input wire logic                    globalClear,
	input wire logic                    backBtn,
	input wire logic                    buzzerMute,
	input wire logic                    clearActiveEn,
	input wire logic                    buzzerRelay_ff,
	input wire logic [NUM_ALARMS-1:0]   latchRelease_ff,
	input wire logic [NUM_ALARMS-1:0]   alarmActive_ff,
	input wire logic [NUM_ALARMS-1:0]   alarmAcked_ff,
	input wire logic [NUM_ALARMS-1:0]   alarmUnack_ff,
	input wire logic                    evtValid,
	input wire logic                    evtReady,
	input wire logic [`ALARM_IDX_W-1:0] evtIndex_ff,
	input wire logic                    evtOn_ff,
	input wire event_group_t            evtGroup_ff,
	input wire logic [`STAMP_W-1:0]     evtStamp_ff
);
	// Cycles since reset: the time base every stamp must follow
	logic [`STAMP_W-1:0]                cycCnt;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cycCnt <= '0;
		end else begin
			cycCnt <= cycCnt + `STAMP_W'(1);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	stamp_time_a: assert property (
		evtValid && !$past(evtValid && !evtReady) |->
		evtStamp_ff == cycCnt - `STAMP_W'(1)) else $error("stamp off");
	grp_match_a: assert property (evtValid |->
		evtGroup_ff == evtIndex_ff[6:5]) else $error("group mismatch");
	evt_hold_a: assert property (evtValid && !evtReady |=> evtValid &&
		$stable(evtIndex_ff) && $stable(evtOn_ff)) else $error("word lost");
	buzz_set_a: assert property (
		|(alarmActive_ff & ~$past(alarmActive_ff)) |-> buzzerRelay_ff)
		else $error("buzzer not set");
	mute_quiet_a: assert property (
		buzzerMute && !(|(alarmIn & ~alarmActive_ff)) |=> !buzzerRelay_ff)
		else $error("mute ignored");
	back_quiet_a: assert property (
		$rose(backBtn) && !(|(alarmIn & ~alarmActive_ff)) |=> !buzzerRelay_ff)
		else $error("back ignored");
	gclear_all_a: assert property (globalClear && !(|latchedSrc) &&
		!(|(alarmActive_ff & ~alarmAcked_ff & ~alarmIn)) |=>
		!(|(alarmUnack_ff & ~alarmActive_ff))) else $error("clear missed");
	no_active_ack_a: assert property (!clearActiveEn |=>
		!(|(alarmAcked_ff & ~$past(alarmAcked_ff)))) else $error("acked");
	release_pulse_a: assert property (|latchRelease_ff |=>
		!(|(latchRelease_ff & $past(latchRelease_ff))))
		else $error("release too long");
endmodule

bind alarm_annunciator alarm_annunciator_sva #(.NUM_ALARMS(NUM_ALARMS)) chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .alarmIn(alarmIn),
	.latchedSrc(latchedSrc), .globalClear(globalClear), .backBtn(backBtn),
	.buzzerMute(buzzerMute), .clearActiveEn(clearActiveEn),
	.buzzerRelay_ff(buzzerRelay_ff), .latchRelease_ff(latchRelease_ff),
	.alarmActive_ff(alarmActive_ff), .alarmAcked_ff(alarmAcked_ff),
	.alarmUnack_ff(alarmUnack_ff), .evtValid(evtValid),
	.evtReady(evtReady), .evtIndex_ff(evtIndex_ff), .evtOn_ff(evtOn_ff),
	.evtGroup_ff(evtGroup_ff), .evtStamp_ff(evtStamp_ff));

// [test/alarm_annunciator_tb.sv]
// Testbench of the alarm annunciator.
`timescale 1ns/1ps
`include "alarm_cfg.svh"
module alarm_annunciator_tb;
	import alarm_pkg::*;
	logic clk_sys = 0, rst_b = 0, clearBtn = 0, globalClear = 0;
	logic backBtn = 0, buzzerMute = 0, clearActiveEn = 0, stall = 0;
	logic clrLog = 0, buzzerRelay_ff, anyUnack_ff, evtValid, evtReady;
	logic evtOn_ff, evtToBuffer_ff, evtToHistory_ff, relSeen;
	logic [1:0] eventSel = `EVT_SEL_BOTH;
	logic [127:0] alarmIn = '0, latchedSrc = '0, historyMask = '0;
	logic [127:0] latchRelease_ff, alarmActive_ff, alarmAcked_ff;
	logic [127:0] alarmUnack_ff;
	logic [`ALARM_IDX_W-1:0] evtIndex_ff;
	logic [`STAMP_W-1:0] evtStamp_ff;
	event_group_t evtGroup_ff;
	logic [9:0] logWord [8];
	int logCnt, err_count = 0, cmp_count = 0;

	always #5 clk_sys = !clk_sys;

	alarm_annunciator dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.alarmIn(alarmIn), .latchedSrc(latchedSrc), .clearBtn(clearBtn),
		.globalClear(globalClear), .backBtn(backBtn),
		.buzzerMute(buzzerMute), .clearActiveEn(clearActiveEn),
		.eventSel(eventSel), .historyMask(historyMask),
		.buzzerRelay_ff(buzzerRelay_ff), .latchRelease_ff(latchRelease_ff),
		.alarmActive_ff(alarmActive_ff), .alarmAcked_ff(alarmAcked_ff),
		.alarmUnack_ff(alarmUnack_ff), .anyUnack_ff(anyUnack_ff),
		.evtValid(evtValid), .evtReady(evtReady), .evtIndex_ff(evtIndex_ff),
		.evtOn_ff(evtOn_ff), .evtGroup_ff(evtGroup_ff),
		.evtToBuffer_ff(evtToBuffer_ff), .evtToHistory_ff(evtToHistory_ff),
		.evtStamp_ff(evtStamp_ff));
	evt_sink sink (.clk_sys(clk_sys), .evtValid(evtValid),
		.evtIndex_ff(evtIndex_ff), .evtOn_ff(evtOn_ff),
		.evtToBuffer_ff(evtToBuffer_ff), .evtToHistory_ff(evtToHistory_ff),
		.stall(stall), .clrLog(clrLog), .evtReady(evtReady),
		.logWord(logWord), .logCnt(logCnt));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task newlog;
		clrLog = 1;
		tick(1);
		clrLog = 0;
	endtask
	// Bounded wait on the buffer model, then a grace for stray words
	task drain(input int n);
		for (int i = 0; i < 300 && logCnt < n; i++)
			tick(1);
		tick(4);
	endtask
	task stop_test;
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_sel;
		logic hist, keepOn, keepOff;
		for (int s = 0; s < 4; s++) begin
			newlog();
			eventSel = 2'(s);
			hist = (s == 2);
			keepOn = (s != 2);
			keepOff = (s != 1);
			historyMask[5] = hist;
			alarmIn[5] = 1;
			tick(2);
			alarmIn[5] = 0;
			drain(int'(keepOn | hist) + int'(keepOff));
			check("count", 16'(int'(keepOn | hist) + int'(keepOff)),
				16'(logCnt));
			if (keepOn | hist)
				check("onword", {hist, keepOn, 1'b1, 7'h05}, logWord[0]);
			if (keepOff)
				check("offword", {2'b01, 1'b0, 7'h05},
					logWord[keepOn | hist]);
		end
		historyMask = '0;
	endtask
	task t_order;
		int idx [3] = '{2, 39, 99};
		eventSel = `EVT_SEL_BOTH_B;
		for (int on = 1; on >= 0; on--) begin
			newlog();
			stall = 1;
			for (int i = 2; i >= 0; i--)
				alarmIn[idx[i]] = 1'(on);
			tick(5);
			stall = 0;
			drain(3);
			check("ordcnt", 16'h0003, 16'(logCnt));
			for (int i = 0; i < 3; i++)
				check("order", {2'b01, 1'(on), 7'(idx[i])}, logWord[i]);
		end
	endtask
	// Buzzer is still on from the earlier activations
	task t_buzz;
		buzzerMute = 1;
		tick(1);
		buzzerMute = 0;
		check("mute", 16'h0000, buzzerRelay_ff);
		alarmIn[20] = 1;
		tick(2);
		check("buzzon", 16'h0001, buzzerRelay_ff);
		backBtn = 1;
		tick(1);
		backBtn = 0;
		check("back", 16'h0000, buzzerRelay_ff);
		alarmIn[21] = 1;
		tick(2);
		check("buzzon2", 16'h0001, buzzerRelay_ff);
	endtask
	task press;
		clearBtn = 1;
		tick(1);
		clearBtn = 0;
		tick(1);
	endtask
	task t_clear;
		alarmIn = '0;
		tick(2);
		globalClear = 1;
		tick(1);
		globalClear = 0;
		tick(2);
		check("gclear", 16'h0000, anyUnack_ff);
		alarmIn[8] = 1;
		tick(2);
		press();
		check("noack", 16'h0000, alarmAcked_ff[8]);
		clearActiveEn = 1;
		press();
		check("ack", 16'h0001, alarmAcked_ff[8]);
		check("active", 16'h0001, alarmActive_ff[8]);
		alarmIn[8] = 0;
		alarmIn[7] = 1;
		tick(2);
		check("ackdrop", 16'h0000, alarmUnack_ff[8]);
		alarmIn[7] = 0;
		tick(10);
		check("unack", 16'h0001, alarmUnack_ff[7]);
		press();
		check("btnclr", 16'h0000, alarmUnack_ff[7]);
	endtask
	// Reset drops the back arming left over from t_buzz
	task t_latch;
		rst_b = 0;
		tick(2);
		rst_b = 1;
		tick(1);
		latchedSrc[9] = 1;
		alarmIn[9] = 1;
		tick(2);
		alarmIn[9] = 0;
		tick(2);
		globalClear = 1;
		tick(1);
		globalClear = 0;
		tick(1);
		check("latchhold", 16'h0001, alarmUnack_ff[9]);
		backBtn = 1;
		tick(1);
		backBtn = 0;
		globalClear = 1;
		tick(1);
		globalClear = 0;
		relSeen = latchRelease_ff[9];
		tick(1);
		check("release", 16'h0001, relSeen);
		check("relend", 16'h0000, latchRelease_ff[9]);
		check("latchclr", 16'h0000, alarmUnack_ff[9]);
	endtask

	initial begin
		#20000;
		err_count++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		#1;
		rst_b = 1;
		tick(1);
		t_sel();
		t_order();
		t_buzz();
		t_clear();
		t_latch();
		stop_test();
	end
endmodule
